// ---- core/psr_defs.svh ----
// Register offsets, field positions, write masks and reset values.
`ifndef PSR_DEFS_SVH
`define PSR_DEFS_SVH

// System control space base, upper address bits compared on decode.
`define PSR_BASE_ADDR 32'h400F_E000
`define PSR_BASE_HI 20'h400FE

// Register byte offsets within the system control space.
`define PSR_OFS_RC0 12'h040
`define PSR_OFS_RC1 12'h044

// Reset value of both reset-control registers.
`define PSR_RC_RESET 32'h0000_0000

// Implemented (read-write) bits; all others are reserved and read zero.
`define PSR_RC0_WMASK 32'h0700_0048
`define PSR_RC1_WMASK 32'h000F_1033

// Field positions in the first reset-control register.
`define PSR_BIT_AB2 26
`define PSR_BIT_AB1 25
`define PSR_BIT_AB0 24
`define PSR_BIT_SLEEP 6
`define PSR_BIT_WDOG 3

// Field positions in the second reset-control register.
`define PSR_BIT_GPC3 19
`define PSR_BIT_GPC2 18
`define PSR_BIT_GPC1 17
`define PSR_BIT_GPC0 16
`define PSR_BIT_TW0 12
`define PSR_BIT_SS1 5
`define PSR_BIT_SS0 4
`define PSR_BIT_AP1 1
`define PSR_BIT_AP0 0

`endif

// ---- core/psr_pkg.sv ----
// Types shared by the peripheral soft reset control block.
package psr_pkg;

  // Bus slave states, one-hot.
  typedef enum logic [1:0] {
    PSR_IDLE = 2'h1,
    PSR_ACK = 2'h2
  } psr_state_t;

  // Whole state of the top module.
  typedef struct packed {
    psr_state_t st;
    logic [31:0] rc0;
    logic [31:0] rc1;
    logic [31:0] rdat;
  } psr_regs_t;

endpackage

// ---- core/psr_wmask.sv ----
// Masked register write: byte lanes, capability word and writable bits.
`timescale 1ns/1ps
module psr_wmask (
  input wire logic [31:0] cur,
  input wire logic [31:0] wdat,
  input wire logic [3:0] sel,
  input wire logic [31:0] cap,
  input wire logic [31:0] wmask,
  input wire logic en,
  output logic [31:0] nxt
);

  logic [31:0] lane_mask;
  logic [31:0] bit_mask;

  // Only bits that are implemented, present and in a selected lane change.
  always_comb begin
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    bit_mask = lane_mask & cap & wmask;
    if (en) begin
      nxt = (cur & ~bit_mask) | (wdat & bit_mask);
    end else begin
      nxt = cur;
    end
  end

endmodule

// ---- core/psr_ctrl.sv ----
// Peripheral soft reset control registers behind a classic Wishbone slave.
// Behaviour
// (R1) First-register writes are ignored where capability_word_1 is clear.
// (R2) Writes to the second register are masked by capability_word_2.
// (R3) Bits 26, 25, 24 of the first register reset area bus units 2, 1, 0.
// (R4) Bit 6 of the first register resets the sleep/power module.
// (R5) Bit 3 of the first register resets the watchdog.
// (R6) Bits 19 to 16 of the second register reset counters 3 to 0.
// (R7) Bit 12 of the second register resets two-wire unit 0.
// (R8) Bits 5 and 4 of the second register reset sync serial units 1 and 0.
// (R9) Bits 1 and 0 of the second register reset async ports 1 and 0.
// (R10) Reserved bits are read-only zero and software keeps them on writes.
// (R11) Both registers clear to zero at reset, holding nothing in reset.
// (R12) The registers sit at base 0x400FE000, offsets 0x040 and 0x044.
// (R13) A set bit holds its peripheral in reset; clearing it releases it.
`timescale 1ns/1ps
`include "psr_defs.svh"
module psr_ctrl (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [31:0] capability_word_1,
  input wire logic [31:0] capability_word_2,
  output logic area_bus_unit2_reset,
  output logic area_bus_unit1_reset,
  output logic area_bus_unit0_reset,
  output logic sleep_module_reset,
  output logic watchdog_reset,
  output logic gp_counter_3_reset,
  output logic gp_counter_2_reset,
  output logic gp_counter_1_reset,
  output logic gp_counter_0_reset,
  output logic two_wire_0_reset,
  output logic sync_serial_1_reset,
  output logic sync_serial_0_reset,
  output logic async_port_1_reset,
  output logic async_port_0_reset
);

  psr_pkg::psr_regs_t q_ff;
  psr_pkg::psr_regs_t nxt_q;
  logic req;
  logic wr_ack;
  logic wr0;
  logic wr1;
  logic [31:0] nxt_rc0;
  logic [31:0] nxt_rc1;

  // True when the address hits the given offset in system control space.
  function automatic logic psr_hit(input logic [31:0] adr,
                                   input logic [11:0] ofs);
    psr_hit = (adr[31:12] == `PSR_BASE_HI) && (adr[11:0] == ofs);
  endfunction

  // Read data for an address; unmapped addresses read zero.
  function automatic logic [31:0] psr_read(input logic [31:0] adr,
                                           input logic [31:0] r0,
                                           input logic [31:0] r1);
    if (psr_hit(adr, `PSR_OFS_RC0)) begin
      psr_read = r0;
    end else if (psr_hit(adr, `PSR_OFS_RC1)) begin
      psr_read = r1;
    end else begin
      psr_read = 32'h0000_0000;
    end
  endfunction

  // Request qualifiers; a write lands on the edge that samples ack high.
  assign req = wb_cyc_i && wb_stb_i;
  assign wr_ack = req && wb_we_i && (q_ff.st == psr_pkg::PSR_ACK);
  assign wr0 = wr_ack && psr_hit(wb_adr_i, `PSR_OFS_RC0); // R12
  assign wr1 = wr_ack && psr_hit(wb_adr_i, `PSR_OFS_RC1); // R12

  // First register: capability_word_1 gates each bit; reserved stay zero.
  psr_wmask u_wmask0 (
    .cur(q_ff.rc0),
    .wdat(wb_dat_i),
    .sel(wb_sel_i),
    .cap(capability_word_1), // R1
    .wmask(`PSR_RC0_WMASK), // R10
    .en(wr0),
    .nxt(nxt_rc0)
  );

  // Second register: capability_word_2 gates each bit; reserved stay zero.
  psr_wmask u_wmask1 (
    .cur(q_ff.rc1),
    .wdat(wb_dat_i),
    .sel(wb_sel_i),
    .cap(capability_word_2), // R2
    .wmask(`PSR_RC1_WMASK), // R10
    .en(wr1),
    .nxt(nxt_rc1)
  );

  // Slave sequence: take a request, answer one cycle later, then rest.
  // The rest cycle lets ack fall even if the master keeps cyc high.
  always_comb begin
    nxt_q = q_ff;
    case (q_ff.st)
      psr_pkg::PSR_IDLE: begin
        if (req) begin
          nxt_q.rdat = psr_read(wb_adr_i, q_ff.rc0, q_ff.rc1); // R12
          nxt_q.st = psr_pkg::PSR_ACK;
        end
      end
      psr_pkg::PSR_ACK: begin
        nxt_q.rc0 = nxt_rc0; // R1
        nxt_q.rc1 = nxt_rc1; // R2
        nxt_q.st = psr_pkg::PSR_IDLE;
      end
      default: begin
        nxt_q.st = psr_pkg::PSR_IDLE;
      end
    endcase
  end

  // State register; registers clear so no peripheral is held in reset.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q_ff.st <= psr_pkg::PSR_IDLE;
      q_ff.rc0 <= `PSR_RC_RESET; // R11
      q_ff.rc1 <= `PSR_RC_RESET; // R11
      q_ff.rdat <= 32'h0000_0000;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // Bus answer comes straight from flip-flops.
  assign wb_ack_o = (q_ff.st == psr_pkg::PSR_ACK);
  assign wb_dat_o = q_ff.rdat;

  // Each set bit holds its unit in reset until software clears it.
  assign area_bus_unit2_reset = q_ff.rc0[`PSR_BIT_AB2]; // R3
  assign area_bus_unit1_reset = q_ff.rc0[`PSR_BIT_AB1]; // R3
  assign area_bus_unit0_reset = q_ff.rc0[`PSR_BIT_AB0]; // R3
  assign sleep_module_reset = q_ff.rc0[`PSR_BIT_SLEEP]; // R4
  assign watchdog_reset = q_ff.rc0[`PSR_BIT_WDOG]; // R5
  assign gp_counter_3_reset = q_ff.rc1[`PSR_BIT_GPC3]; // R6
  assign gp_counter_2_reset = q_ff.rc1[`PSR_BIT_GPC2]; // R6
  assign gp_counter_1_reset = q_ff.rc1[`PSR_BIT_GPC1]; // R6
  assign gp_counter_0_reset = q_ff.rc1[`PSR_BIT_GPC0]; // R6
  assign two_wire_0_reset = q_ff.rc1[`PSR_BIT_TW0]; // R7
  assign sync_serial_1_reset = q_ff.rc1[`PSR_BIT_SS1]; // R8
  assign sync_serial_0_reset = q_ff.rc1[`PSR_BIT_SS0]; // R8
  assign async_port_1_reset = q_ff.rc1[`PSR_BIT_AP1]; // R9
  assign async_port_0_reset = q_ff.rc1[`PSR_BIT_AP0]; // R9

  // An absent area bus unit keeps its bit whatever is written.
  chk_absent_bit_held: // R1
    assert property (@(posedge core_clk) disable iff (!rst_b)
      wr0 && !capability_word_1[`PSR_BIT_AB0]
      |=> q_ff.rc0[`PSR_BIT_AB0] == $past(q_ff.rc0[`PSR_BIT_AB0]))
    else $error("absent unit bit changed in first register");

  // An absent counter keeps its bit whatever is written.
  chk_cap2_mask_holds: // R2
    assert property (@(posedge core_clk) disable iff (!rst_b)
      wr1 && !capability_word_2[`PSR_BIT_GPC2]
      |=> q_ff.rc1[`PSR_BIT_GPC2] == $past(q_ff.rc1[`PSR_BIT_GPC2]))
    else $error("absent counter bit changed in second register");

  // Area bus unit bits take written data where present.
  chk_area_bits_write: // R3
    assert property (@(posedge core_clk) disable iff (!rst_b)
      wr0 && wb_sel_i[3] && (capability_word_1[26:24] == 3'h7)
      |=> {area_bus_unit2_reset, area_bus_unit1_reset,
           area_bus_unit0_reset} == $past(wb_dat_i[26:24]))
    else $error("area bus unit reset bits did not follow write");

  // Sleep module bit follows a present, selected write.
  chk_sleep_bit_write: // R4
    assert property (@(posedge core_clk) disable iff (!rst_b)
      wr0 && wb_sel_i[0] && capability_word_1[`PSR_BIT_SLEEP]
      |=> sleep_module_reset == $past(wb_dat_i[`PSR_BIT_SLEEP]))
    else $error("sleep module reset did not follow write");

  // Watchdog reset is high one edge after a write that sets it and stays high one more edge.
  chk_wdog_set_hold: // R5
    assert property (@(posedge core_clk) disable iff (!rst_b)
      wr0 && wb_sel_i[0] && capability_word_1[`PSR_BIT_WDOG]
      && wb_dat_i[`PSR_BIT_WDOG] |=> watchdog_reset ##1 watchdog_reset)
    else $error("watchdog reset not held after set");

  // Counter bits take written data where present.
  chk_counter_bits_write: // R6
    assert property (@(posedge core_clk) disable iff (!rst_b)
      wr1 && wb_sel_i[2] && (capability_word_2[19:16] == 4'hF)
      |=> {gp_counter_3_reset, gp_counter_2_reset, gp_counter_1_reset,
           gp_counter_0_reset} == $past(wb_dat_i[19:16]))
    else $error("counter reset bits did not follow write");

  // Two-wire bit follows byte lane 1 only.
  chk_two_wire_write: // R7
    assert property (@(posedge core_clk) disable iff (!rst_b)
      wr1 && capability_word_2[`PSR_BIT_TW0]
      |=> two_wire_0_reset == ($past(wb_sel_i[1])
          ? $past(wb_dat_i[`PSR_BIT_TW0]) : $past(two_wire_0_reset)))
    else $error("two-wire reset wrong after write");

  // Sync serial bits follow a present, selected write.
  chk_sync_bits_write: // R8
    assert property (@(posedge core_clk) disable iff (!rst_b)
      wr1 && wb_sel_i[0] && (capability_word_2[5:4] == 2'h3)
      |=> {sync_serial_1_reset, sync_serial_0_reset}
          == $past(wb_dat_i[5:4]))
    else $error("sync serial reset bits did not follow write");

  // Async port bits follow a present, selected write.
  chk_async_bits_write: // R9
    assert property (@(posedge core_clk) disable iff (!rst_b)
      wr1 && wb_sel_i[0] && (capability_word_2[1:0] == 2'h3)
      |=> {async_port_1_reset, async_port_0_reset}
          == $past(wb_dat_i[1:0]))
    else $error("async port reset bits did not follow write");

  // Reserved bits never hold a one.
  chk_reserved_read_zero: // R10
    assert property (@(posedge core_clk) disable iff (!rst_b)
      ((q_ff.rc0 & ~`PSR_RC0_WMASK) == 32'h0000_0000)
      && ((q_ff.rc1 & ~`PSR_RC1_WMASK) == 32'h0000_0000))
    else $error("reserved reset-control bit is set");

  // Both registers are zero at the first edge after reset release.
  chk_reset_clears_all: // R11
    assert property (@(posedge core_clk) disable iff (!rst_b)
      $rose(rst_b) |-> (q_ff.rc0 == `PSR_RC_RESET)
      && (q_ff.rc1 == `PSR_RC_RESET) && !wb_ack_o)
    else $error("reset-control registers not clear after reset");

  // A read of the second offset answers next cycle with its contents.
  chk_read_decode_rc1: // R12
    assert property (@(posedge core_clk) disable iff (!rst_b)
      req && !wb_we_i && (q_ff.st == psr_pkg::PSR_IDLE)
      && (wb_adr_i == (`PSR_BASE_ADDR | 32'h0000_0044))
      |=> wb_ack_o && (wb_dat_o == q_ff.rc1) ##1 !wb_ack_o)
    else $error("read of second register answered wrongly");

  // Clearing a set watchdog bit releases the unit on the next edge.
  chk_release_on_clear: // R13
    assert property (@(posedge core_clk) disable iff (!rst_b)
      wr0 && watchdog_reset && wb_sel_i[0]
      && capability_word_1[`PSR_BIT_WDOG] && !wb_dat_i[`PSR_BIT_WDOG]
      |=> !watchdog_reset)
    else $error("watchdog not released after clear");

  // Ack stands for one cycle only; the slave always rests after it.
  chk_ack_single_pulse: // R12
    assert property (@(posedge core_clk) disable iff (!rst_b)
      wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  // A request taken while idle is answered on the next cycle.
  chk_ack_after_take: // R12
    assert property (@(posedge core_clk) disable iff (!rst_b)
      req && (q_ff.st == psr_pkg::PSR_IDLE) |=> wb_ack_o)
    else $error("request taken but not answered next cycle");

  // A read of the first offset answers next cycle with its contents.
  chk_read_decode_rc0: // R12
    assert property (@(posedge core_clk) disable iff (!rst_b)
      req && !wb_we_i && (q_ff.st == psr_pkg::PSR_IDLE)
      && (wb_adr_i == (`PSR_BASE_ADDR | 32'h0000_0040))
      |=> wb_ack_o && (wb_dat_o == $past(q_ff.rc0)))
    else $error("read of first register answered wrongly");

  // Addresses outside the two registers read as zero.
  chk_unmapped_read_zero: // R12
    assert property (@(posedge core_clk) disable iff (!rst_b)
      req && !wb_we_i && (q_ff.st == psr_pkg::PSR_IDLE)
      && !psr_hit(wb_adr_i, `PSR_OFS_RC0)
      && !psr_hit(wb_adr_i, `PSR_OFS_RC1)
      |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped address did not read zero");

  // A write that hits neither register leaves both untouched.
  chk_unmapped_write_kept: // R12
    assert property (@(posedge core_clk) disable iff (!rst_b)
      wr_ack && !wr0 && !wr1
      |=> (q_ff.rc0 == $past(q_ff.rc0)) && (q_ff.rc1 == $past(q_ff.rc1)))
    else $error("unmapped write changed a reset-control register");

  // Reset lines move only at the edge that ends an acked write.
  chk_lines_held_idle: // R13
    assert property (@(posedge core_clk) disable iff (!rst_b)
      !wr_ack |=> (q_ff.rc0 == $past(q_ff.rc0))
      && (q_ff.rc1 == $past(q_ff.rc1)))
    else $error("reset-control register changed without a write");

  // An absent watchdog keeps its bit whatever is written.
  chk_absent_wdog_held: // R1
    assert property (@(posedge core_clk) disable iff (!rst_b)
      wr0 && !capability_word_1[`PSR_BIT_WDOG]
      |=> watchdog_reset == $past(watchdog_reset))
    else $error("absent watchdog bit changed in first register");

  // An absent async port keeps its bit whatever is written.
  chk_absent_port_held: // R2
    assert property (@(posedge core_clk) disable iff (!rst_b)
      wr1 && !capability_word_2[`PSR_BIT_AP0]
      |=> async_port_0_reset == $past(async_port_0_reset))
    else $error("absent async port bit changed in second register");

endmodule

// ---- tb/psr_ctrl_tb.sv ----
// Self-checking testbench for the peripheral soft reset control block.
`timescale 1ns/1ps
`include "psr_defs.svh"
module psr_ctrl_tb;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [31:0] adr = 32'h0000_0000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] cap1 = 32'hFFFF_FFFF;
  logic [31:0] cap2 = 32'hFFFF_FFFF;
  logic [31:0] rdat;
  logic ack;
  logic [13:0] outs;
  logic [31:0] e0 = 32'h0000_0000;
  logic [31:0] e1 = 32'h0000_0000;
  logic [31:0] q;
  int seed = 32'hE6305B92;
  int n_mismatch = 0;
  int checks = 0;
  localparam logic [31:0] A0 = `PSR_BASE_ADDR + 32'h0000_0040;
  localparam logic [31:0] A1 = `PSR_BASE_ADDR + 32'h0000_0044;

  psr_ctrl i_psr_ctrl (.core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .capability_word_1(cap1), .capability_word_2(cap2),
    .area_bus_unit2_reset(outs[13]), .area_bus_unit1_reset(outs[12]),
    .area_bus_unit0_reset(outs[11]), .sleep_module_reset(outs[10]),
    .watchdog_reset(outs[9]), .gp_counter_3_reset(outs[8]),
    .gp_counter_2_reset(outs[7]), .gp_counter_1_reset(outs[6]),
    .gp_counter_0_reset(outs[5]), .two_wire_0_reset(outs[4]),
    .sync_serial_1_reset(outs[3]), .sync_serial_0_reset(outs[2]),
    .async_port_1_reset(outs[1]), .async_port_0_reset(outs[0]));

  // Free-running 100 MHz clock.
  always #5 core_clk = ~core_clk;

  // New register value: only selected, present and implemented bits move.
  function automatic logic [31:0] upd(input logic [31:0] cur,
      input logic [31:0] d, input logic [3:0] s, input logic [31:0] cap,
      input logic [31:0] wm);
    logic [31:0] m;
    for (int i = 0; i < 4; i++) begin
      m[8*i +: 8] = {8{s[i]}};
    end
    m = m & cap & wm;
    return (cur & ~m) | (d & m);
  endfunction

  // Compare one value; an unknown bit in what is seen is a mismatch.
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Print the counts and the verdict, then end the run.
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One classic cycle; ack is sampled at each rising edge, and the request
  // is released right after the edge that sees it high, or after 20 edges without it.
  task automatic xfer(input logic w, input logic [31:0] a,
      input logic [3:0] s, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    r = 32'h0000_0000;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    chk("ack", 32'h0000_0001, {31'h0, ack});
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // Access plus model update; unmapped reads must return zero.
  task automatic op(input logic w, input logic [31:0] a,
      input logic [3:0] s, input logic [31:0] d);
    xfer(w, a, s, d, q);
    if (w && a === A0) e0 = upd(e0, d, s, cap1, `PSR_RC0_WMASK);
    if (w && a === A1) e1 = upd(e1, d, s, cap2, `PSR_RC1_WMASK);
    if (!w && a !== A0 && a !== A1) chk("unmapped", 32'h0, q);
  endtask

  // Read both registers back and compare the reset lines with the model.
  task automatic verify();
    xfer(1'b0, A0, 4'hF, 32'h0, q);
    chk("reg0", e0, q);
    xfer(1'b0, A1, 4'hF, 32'h0, q);
    chk("reg1", e1, q);
    // Reads never move the lines, so the edge value is settled.
    @(posedge core_clk);
    chk("lines", {18'h0, e0[26], e0[25], e0[24], e0[6], e0[3], e1[19:16],
      e1[12], e1[5], e1[4], e1[1], e1[0]}, {18'h0, outs});
  endtask

  // Watchdog in case the bus never answers.
  initial begin
    repeat (40000) @(posedge core_clk);
    n_mismatch++;
    wrap_up();
  end

  // Main sequence: corner cases first, then random traffic.
  initial begin
    logic [31:0] a;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    verify();
    op(1'b1, A0, 4'hF, 32'hFFFF_FFFF);
    op(1'b1, A1, 4'hF, 32'hFFFF_FFFF);
    verify();
    cap1 <= 32'h0000_0000;
    cap2 <= 32'h0000_0000;
    op(1'b1, A0, 4'hF, 32'h0);
    op(1'b1, A1, 4'hF, 32'h0);
    verify();
    cap1 <= 32'hFFFF_FFFF;
    cap2 <= 32'hFFFF_FFFF;
    op(1'b1, A0, 4'hF, 32'h0);
    op(1'b1, A1, 4'hF, 32'h0);
    verify();
    cap1 <= 32'h0000_0000;
    cap2 <= 32'h0000_0000;
    op(1'b1, A0, 4'hF, 32'hFFFF_FFFF);
    op(1'b1, A1, 4'hF, 32'hFFFF_FFFF);
    verify();
    cap1 <= 32'hFFFF_FFFF;
    cap2 <= 32'hFFFF_FFFF;
    op(1'b1, `PSR_BASE_ADDR + 32'h48, 4'hF, 32'hFFFF_FFFF);
    op(1'b1, 32'h500F_E040, 4'hF, 32'hFFFF_FFFF);
    op(1'b0, 32'h500F_E044, 4'hF, 32'h0);
    verify();
    for (int i = 0; i < 80; i++) begin
      case ($unsigned($random(seed)) % 4)
        0, 1: a = A0;
        2: a = A1;
        default: a = `PSR_BASE_ADDR + 32'h48;
      endcase
      if (i % 3 == 1) a = A1;
      cap1 <= $random(seed);
      cap2 <= $random(seed);
      op($random(seed), a, $random(seed), $random(seed));
      verify();
    end
    // Mid-run reset must clear both registers again.
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    e0 = 32'h0;
    e1 = 32'h0;
    verify();
    wrap_up();
  end
endmodule
